// ---- logic/mssel_defines.svh ----
// Constants for the multi-speed binary select block.
// Assumes inclusion by bare name from the design files.
`ifndef MSSEL_DEFINES_SVH
`define MSSEL_DEFINES_SVH
// ============================================================
// Register map (byte addresses, one aligned word each)
`define MSSEL_ADDR_CTRL      12'h000
`define MSSEL_ADDR_MAP       12'h004
`define MSSEL_ADDR_BASE      12'h008
`define MSSEL_ADDR_MAXF      12'h00C
`define MSSEL_ADDR_STAGE     12'h010
`define MSSEL_ADDR_COMMIT    12'h014
`define MSSEL_ADDR_STATUS    12'h018
`define MSSEL_ADDR_TABLE     12'h040
`define MSSEL_ADDR_TABLE_END 12'h07C
// ============================================================
// Field layouts and reset values
`define MSSEL_MAP_FIELD_W    4
`define MSSEL_MAP_EN_BIT     3
`define MSSEL_CTRL_RUN_BIT   0
// Bit positions used by the bus decode and the select map.
`define MSSEL_MAP_TERM_MSB   2
`define MSSEL_TIX_MSB        5
`define MSSEL_TIX_LSB        2
`define MSSEL_CIX_MSB        3
`define MSSEL_ALIGN_MSB      1
`define MSSEL_HALF_W         16
`define MSSEL_RST_MAP        16'h0000
`define MSSEL_RST_FREQ       16'h0000
`define MSSEL_RST_MAXF       16'hFFFF
`define MSSEL_ZERO_IDX       4'h0
`define MSSEL_ONE_IDX        4'h1
`endif

// ---- logic/mssel_pkg.sv ----
// Types shared by the multi-speed select block.
// Assumes the defines header is compiled alongside.
package mssel_pkg;
  // ============================================================
  // APB request carrier.
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } mssel_apb_req_t;
  // Target output carrier.
  typedef struct packed {
    logic [15:0] freq;
    logic [3:0]  index;
    logic        clamped;
  } mssel_target_t;
endpackage

// ---- logic/mssel_sync.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs and one clock pclk.
`timescale 1ns/1ns
module mssel_sync #(
  parameter int W = 7
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Raw and filtered levels.
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  // ============================================================
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] dout_nxt;

  // The output word changes only when the second and third stages agree in every bit.
  assign dout_nxt = (s2_r == s3_r) ? s3_r : dout;

  // Shift chain and filtered output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout <= dout_nxt;
    end
  end
endmodule

// ---- logic/mssel_top.sv ----
// Multi-speed binary select: sixteen-entry target table chosen by four
// remappable select inputs, registers over APB.
// Assumes terminals are asynchronous levels; APB master on pclk.
// Assumes the package and the defines header are compiled with this file.
// Register map, one aligned word each, data in the low half-word except STATUS, which uses bits 20 to 0:
//   CTRL holds the run bit; the target is zero while it is clear.
//   MAP holds four nibbles, nibble k placing select bit k on a terminal.
//   BASE holds the speed used for index zero.
//   MAXF holds the ceiling applied to every selected speed.
//   STAGE holds the edit value, harmless until it is stored.
//   COMMIT is the store action: STAGE goes to the entry named by the data.
//   STATUS shows the clamp flag, the index and the next target.
//   TABLE shows sixteen read-only entries; entry zero is never used.
// A terminal change reaches the outputs six cycles later.
// The synchroniser costs four cycles and the index and output stages two.
// Every output of this module comes straight from a flip-flop.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "mssel_defines.svh"
module mssel_top
  import mssel_pkg::*;
#(
  parameter int NTERM = 7,
  parameter int NSPD  = 16,
  parameter int FW    = 16
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave.
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic      [31:0]      prdata,
  output logic                  pslverr,
  // Input terminals.
  input  wire logic [NTERM-1:0] terminal_in,
  // Target frequency out.
  output logic      [FW-1:0]    target_freq,
  output logic      [3:0]       speed_index,
  output logic                  target_clamped,
  output logic                  run_active
);
  // ============================================================
  // Storage and configuration. Entry zero of the table is never read for the
  // target: index zero always takes the base source instead.
  logic [FW-1:0]  table_r [NSPD];
  logic [FW-1:0]  base_frequency_source_r;
  logic [FW-1:0]  max_output_frequency_r;
  logic [FW-1:0]  stage_r;
  logic [15:0]    map_r;
  logic           run_r;
  logic [NTERM-1:0] term_s;
  logic [3:0]     idx_r;
  mssel_apb_req_t req;
  mssel_target_t  tgt_nxt;

  // Decode helper: a select bit from its map nibble; an unassigned bit is zero.
  function automatic logic sel_bit(input logic [3:0] fld, input logic [NTERM-1:0] t);
    logic [`MSSEL_MAP_TERM_MSB:0] term;
    logic                         hit;
    term = fld[`MSSEL_MAP_TERM_MSB:0];
    hit  = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (int'(term) == i) begin
        hit = t[i];
      end
    end
    return fld[`MSSEL_MAP_EN_BIT] & hit;
  endfunction

  // Map nibble that places select bit k.
  function automatic logic [3:0] map_fld(input logic [15:0] m, input int k);
    return m[k*`MSSEL_MAP_FIELD_W +: `MSSEL_MAP_FIELD_W];
  endfunction

  // Word decode: true when the bus address names the given register.
  function automatic logic at_reg(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // Terminal synchroniser. Every terminal passes three flops and a level is
  // taken once the last two agree, which hides a single-cycle glitch.
  mssel_sync #(.W(NTERM)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (terminal_in),
    .dout    (term_s)
  );

  // ============================================================
  // Bus decode.
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  wire acc       = req.sel & req.enable;
  wire wr        = acc & req.write;
  // Setup cycle: the registered answer is prepared here.
  wire setup     = req.sel & ~req.enable;
  wire in_table  = (req.addr >= `MSSEL_ADDR_TABLE) && (req.addr <= `MSSEL_ADDR_TABLE_END);
  wire [3:0] tix = req.addr[`MSSEL_TIX_MSB:`MSSEL_TIX_LSB];
  wire hit_ctrl  = at_reg(req.addr, `MSSEL_ADDR_CTRL);
  wire hit_map   = at_reg(req.addr, `MSSEL_ADDR_MAP);
  wire hit_base  = at_reg(req.addr, `MSSEL_ADDR_BASE);
  wire hit_maxf  = at_reg(req.addr, `MSSEL_ADDR_MAXF);
  wire hit_stage = at_reg(req.addr, `MSSEL_ADDR_STAGE);
  wire hit_comm  = at_reg(req.addr, `MSSEL_ADDR_COMMIT);
  wire hit_stat  = at_reg(req.addr, `MSSEL_ADDR_STATUS);
  wire mapped    = in_table | hit_ctrl | hit_map | hit_base | hit_maxf | hit_stage
                   | hit_comm | hit_stat;
  wire aligned   = ~|req.addr[`MSSEL_ALIGN_MSB:0];
  wire ok        = mapped & aligned;
  // A write lands only at the access edge, while pready stands.
  wire wr_take   = wr & pready & ok;
  // Commit index sits in the write data; index zero is the base source.
  wire [3:0] cix = req.wdata[`MSSEL_CIX_MSB:0];

  // Select bits, each taken from the terminal that its nibble names.
  wire speed_select_bit0 = sel_bit(map_fld(map_r, 0), term_s);
  wire speed_select_bit1 = sel_bit(map_fld(map_r, 1), term_s);
  wire speed_select_bit2 = sel_bit(map_fld(map_r, 2), term_s);
  wire speed_select_bit3 = sel_bit(map_fld(map_r, 3), term_s);

  // Index assembly: the first select is the least significant bit.
  wire [3:0] idx_nxt = {speed_select_bit3, speed_select_bit2,
                        speed_select_bit1, speed_select_bit0};

  // Target selection and ceiling clamp. A speed above the ceiling is held at
  // the ceiling and flagged, so a table entry can never push the drive past it.
  // While the run bit is clear the target is forced to zero.
  wire [FW-1:0] raw = (idx_r == `MSSEL_ZERO_IDX) ? base_frequency_source_r
                                                 : table_r[idx_r];
  wire over = raw > max_output_frequency_r;
  assign tgt_nxt = '{freq: run_r ? (over ? max_output_frequency_r : raw) : '0,
                     index: idx_r, clamped: run_r & over};

  // Read mux. Only the setup cycle of a read samples it, so a register that
  // changes in the access cycle still returns its setup-cycle value.
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (in_table)       rd_nxt = {16'h0000, table_r[tix]};
    else if (hit_ctrl)  rd_nxt = {31'h0000_0000, run_r};
    else if (hit_map)   rd_nxt = {16'h0000, map_r};
    else if (hit_base)  rd_nxt = {16'h0000, base_frequency_source_r};
    else if (hit_maxf)  rd_nxt = {16'h0000, max_output_frequency_r};
    else if (hit_stage) rd_nxt = {16'h0000, stage_r};
    else if (hit_stat)  rd_nxt = {11'h000, tgt_nxt.clamped, idx_r, tgt_nxt.freq};
  end

  // ============================================================
  // APB answer: pready, prdata and pslverr stand in the access cycle only.
  // The slave never inserts a wait state, so every access lasts one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= (setup & ~req.write & ok) ? rd_nxt : 32'h0000_0000;
      pslverr <= setup & ~ok;
    end
  end

  // Configuration registers; a commit of index zero refills the base source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_r                   <= `MSSEL_RST_MAP;
      run_r                   <= 1'b0;
      base_frequency_source_r <= `MSSEL_RST_FREQ;
      max_output_frequency_r  <= `MSSEL_RST_MAXF;
      stage_r                 <= `MSSEL_RST_FREQ;
    end else if (wr_take) begin
      if (hit_ctrl)  run_r <= req.wdata[`MSSEL_CTRL_RUN_BIT];
      if (hit_map)   map_r <= req.wdata[`MSSEL_HALF_W-1:0];
      if (hit_base)  base_frequency_source_r <= req.wdata[FW-1:0];
      if (hit_maxf)  max_output_frequency_r <= req.wdata[FW-1:0];
      if (hit_stage) stage_r <= req.wdata[FW-1:0];
      if (hit_comm && cix == `MSSEL_ZERO_IDX) base_frequency_source_r <= stage_r;
    end
  end

  // Stored speed table: only the store action writes an entry.
  // An edited STAGE value that is never committed leaves every entry as it was.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NSPD; i++) table_r[i] <= `MSSEL_RST_FREQ;
    end else if (wr_take && hit_comm && cix != `MSSEL_ZERO_IDX) begin
      table_r[cix] <= stage_r;
    end
  end

  // Registered index and outputs. Every output leaves a flip-flop, and the
  // index stage sits between the filter and the table lookup so that the
  // lookup never sees a half-changed select word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r          <= `MSSEL_ZERO_IDX;
      target_freq    <= `MSSEL_RST_FREQ;
      speed_index    <= `MSSEL_ZERO_IDX;
      target_clamped <= 1'b0;
      run_active     <= 1'b0;
    end else begin
      idx_r          <= idx_nxt;
      target_freq    <= tgt_nxt.freq;
      speed_index    <= tgt_nxt.index;
      target_clamped <= tgt_nxt.clamped;
      run_active     <= run_r;
    end
  end
endmodule

// ---- verification/mssel_top_asserts.sv ----
// Checker for the multi-speed select top-level ports.
// Assumes it is bound onto mssel_top and sees only its ports.
`timescale 1ns/1ns
// ============================================================
// Checker
module mssel_top_asserts #(
  parameter int NTERM = 7,
  parameter int FW    = 16
) (
  // Clock and reset.
  input wire logic             pclk,
  input wire logic             presetn,
  // APB slave side.
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic             pready,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  // Terminals and target.
  input wire logic [NTERM-1:0] terminal_in,
  input wire logic [FW-1:0]    target_freq,
  input wire logic [3:0]       speed_index,
  input wire logic             run_active
);
  logic [3:0] quiet_r;
  // Counts cycles since the last terminal change or bus activity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_r <= 4'h0;
    else if (psel || $changed(terminal_in)) quiet_r <= 4'h0;
    else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle, then a completed access.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_idle3;
    !psel [*3];
  endsequence
  a_setup_ready: assert property (s_setup |=> pready)
    else $error("No pready after setup.");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long.");
  a_idle_noready: assert property (!psel |=> !pready)
    else $error("pready without request.");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready.");
  a_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("Refused read returned data.");
  a_run_write: assert property (s_idle3 |=> $stable(run_active))
    else $error("Run changed without a write.");
  a_stop_zero: assert property (!run_active && !$past(run_active, 2) |-> target_freq == '0)
    else $error("Target nonzero while stopped.");
  a_idx_steady: assert property (quiet_r >= 4'hA |-> $stable(speed_index) && $stable(target_freq))
    else $error("Target moved with quiet inputs.");
  a_idx_bound: assert property ($changed(speed_index) |-> quiet_r <= 4'h8)
    else $error("Index change came too late.");
endmodule
bind mssel_top mssel_top_asserts #(.NTERM(NTERM), .FW(FW)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .pready, .prdata, .pslverr, .terminal_in, .target_freq,
  .speed_index, .run_active);

// ---- verification/mssel_plc.sv ----
// Model of the switch bank that drives the select terminals.
// Assumes selects sit on terminals 1, 4, 0 and 3 for bits 0 to 3.
`timescale 1ns/1ns
// ============================================================
// Switch bank
module mssel_plc (
  // Requested speed index.
  input  wire logic [3:0] idx,
  // Terminal levels, ON is high.
  output logic      [6:0] terminal_in
);
  // Spare terminals 2, 5 and 6 are driven from the index bits so stray terminals are exposed.
  assign terminal_in = {~idx[1], idx[0] ^ idx[3], idx[1], idx[3], ~idx[2], idx[0], idx[2]};
endmodule

// ---- verification/mssel_top_tb.sv ----
// Self-checking bench for the multi-speed select block.
// Assumes the defines header, package, design and checker are compiled first.
`timescale 1ns/1ns
`include "mssel_defines.svh"
// ============================================================
// Bench
module mssel_top_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [3:0]  idx = 4'h0, speed_index;
  logic [6:0]  terminal_in;
  logic [15:0] target_freq, base, tab [16];
  logic        pready, pslverr, target_clamped, run_active;
  logic [32:0] q [$], e;
  int          num_errors = 0, compares = 0, seed = 32'hb172;
  // Free-running bus clock.
  always #2 pclk = ~pclk;
  mssel_plc u_plc (.idx(idx), .terminal_in(terminal_in));
  mssel_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .terminal_in, .target_freq, .speed_index, .target_clamped, .run_active);
  // Compares one value and counts it.
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, x);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic results;
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer, waiting a bounded time for pready.
  task automatic apb(input int w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= (w != 0);
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      results();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Read that leaves its expected answer in the queue.
  task automatic rd(input logic [11:0] a, input int err, input logic [31:0] x);
    q.push_back({err != 0, x});
    apb(0, a, 32'h0000_0000);
  endtask
  // Takes the oldest expectation whenever read data is handed back.
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
    e = q.pop_front();
    check(prdata, e[31:0]);
    check({31'h0, pslverr}, {31'h0, e[32]});
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(`MSSEL_ADDR_MAP, 0, 32'h0000_0000);
    rd(`MSSEL_ADDR_MAXF, 0, 32'h0000_FFFF);
    rd(12'h020, 1, 32'h0000_0000);
    base = 16'($random(seed));
    apb(1, `MSSEL_ADDR_BASE, {16'h0000, ~base});
    apb(1, `MSSEL_ADDR_STAGE, {16'h0000, base});
    apb(1, `MSSEL_ADDR_COMMIT, 32'h0000_0000);
    apb(1, `MSSEL_ADDR_BASE + 12'h002, 32'h0000_0000);
    rd(`MSSEL_ADDR_BASE, 0, {16'h0000, base});
    for (int i = 1; i < 16; i++) begin
      tab[i] = 16'($random(seed));
      apb(1, `MSSEL_ADDR_STAGE, {16'h0000, tab[i]});
      apb(1, `MSSEL_ADDR_COMMIT, 32'(i));
      apb(1, `MSSEL_ADDR_STAGE, {16'h0000, ~tab[i]});
      rd(`MSSEL_ADDR_TABLE + 12'(4 * i), 0, {16'h0000, tab[i]});
    end
    apb(1, `MSSEL_ADDR_MAP, 32'h0000_B8C9);
    apb(1, `MSSEL_ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i < 16; i++) begin
      idx <= 4'(i);
      repeat (10) @(posedge pclk);
      check(speed_index, 32'(i));
      check(target_freq, (i == 0) ? base : tab[i]);
    end
    check(run_active, 32'h0000_0001);
    apb(1, `MSSEL_ADDR_MAP, 32'h0000_00C9);
    idx <= 4'hF;
    repeat (10) @(posedge pclk);
    check(speed_index, 32'h0000_0003);
    apb(1, `MSSEL_ADDR_MAXF, {16'h0000, tab[3] >> 1});
    repeat (10) @(posedge pclk);
    check(target_freq, tab[3] >> 1);
    check(target_clamped, tab[3] != 16'h0000);
    rd(`MSSEL_ADDR_STATUS, 0, {11'h000, tab[3] != 16'h0000, 4'h3, tab[3] >> 1});
    apb(1, `MSSEL_ADDR_CTRL, 32'h0000_0000);
    repeat (10) @(posedge pclk);
    check(target_freq, 32'h0000_0000);
    check(run_active, 32'h0000_0000);
    results();
  end
endmodule
